// ===== common/sfrc_pkg.sv
`default_nettype none

package sfrc_pkg;

  // Read opcodes
  localparam logic [7:0] OP_ARR_LEGACY = 8'hE8;
  localparam logic [7:0] OP_ARR_FAST = 8'h0B;
  localparam logic [7:0] OP_ARR_SLOW = 8'h03;
  localparam logic [7:0] OP_PAGE_RD = 8'hD2;
  localparam logic [7:0] OP_BUF1_FAST = 8'hD4;
  localparam logic [7:0] OP_BUF1_SLOW = 8'hD1;
  localparam logic [7:0] OP_BUF2_FAST = 8'hD6;
  localparam logic [7:0] OP_BUF2_SLOW = 8'hD3;

  // Header bit counts: last index of the opcode and address phases, whole bit count of the dummy phase
  localparam logic [5:0] OPC_LAST = 6'h07;
  localparam logic [5:0] ADDR_LAST = 6'h17;
  localparam logic [5:0] DUMMY_FOUR = 6'h20;
  localparam logic [5:0] DUMMY_ONE = 6'h08;
  localparam logic [5:0] DUMMY_NONE = 6'h00;

  // Address field layout
  localparam int PAGE_W = 13;
  localparam int COL_W = 10;
  localparam int A528_PAGE_LSB = 10;
  localparam int A512_PAGE_LSB = 9;
  localparam logic [9:0] LAST_COL_528 = 10'h20F;
  localparam logic [9:0] LAST_COL_512 = 10'h1FF;
  localparam logic [12:0] PAGE_STEP = 13'h0001;
  localparam logic [9:0] COL_STEP = 10'h001;

  // Values after reset
  localparam logic [5:0] RST_CNT = 6'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [23:0] RST_SHIFT = 24'h000000;
  localparam logic [2:0] RST_BITN = 3'h0;
  localparam logic [12:0] RST_PAGE = 13'h0000;
  localparam logic [9:0] RST_COL = 10'h000;

  // Command sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPC = 3'h1,
    ST_ADDR = 3'h3,
    ST_DUMMY = 3'h2,
    ST_DATA = 3'h6,
    ST_SKIP = 3'h7
  } sfrc_state_t;

  // Behaviour of the read pointer at the end of a page or buffer
  typedef enum logic [1:0] {
    WR_ARRAY = 2'h0,
    WR_PAGE = 2'h1,
    WR_BUF = 2'h2
  } sfrc_wrap_t;

endpackage

`default_nettype wire

// ===== common/sfrc_ctr_if.sv
`default_nettype none

interface sfrc_ctr_if;
  logic ld;
  logic step;
  logic [12:0] ld_page;
  logic [9:0] ld_col;
  sfrc_pkg::sfrc_wrap_t ld_wrap;
  logic ld_pg512;
  logic [12:0] page;
  logic [9:0] col;

  modport ctl (
    output ld, step, ld_page, ld_col, ld_wrap, ld_pg512,
    input page, col
  );

  modport ctr (
    input ld, step, ld_page, ld_col, ld_wrap, ld_pg512,
    output page, col
  );
endinterface

`default_nettype wire

// ===== verilog/sfrc_addr_ctr.sv
`default_nettype none

module sfrc_addr_ctr (
  input wire logic clk_i,
  input wire logic rst_n_i,
  sfrc_ctr_if.ctr ctr
);

  logic [12:0] page_q;
  logic [12:0] page_d;
  logic [9:0] col_q;
  logic [9:0] col_d;
  sfrc_pkg::sfrc_wrap_t wrap_q;
  sfrc_pkg::sfrc_wrap_t wrap_d;
  logic pg512_q;
  logic pg512_d;
  logic [9:0] last_col;

  // Load start address, or advance one byte with wrap
  always_comb
  begin
    page_d = page_q;
    col_d = col_q;
    wrap_d = wrap_q;
    pg512_d = pg512_q;
    last_col = pg512_q ? sfrc_pkg::LAST_COL_512 : sfrc_pkg::LAST_COL_528;
    if (ctr.ld)
    begin
      page_d = ctr.ld_page;
      col_d = ctr.ld_col;
      wrap_d = ctr.ld_wrap;
      pg512_d = ctr.ld_pg512;
    end
    else if (ctr.step)
    begin
      if (col_q == last_col)
      begin
        col_d = sfrc_pkg::RST_COL;
        if (wrap_q == sfrc_pkg::WR_ARRAY)
        begin
          page_d = page_q + sfrc_pkg::PAGE_STEP;
        end
      end
      else
      begin
        col_d = col_q + sfrc_pkg::COL_STEP;
      end
    end
  end

  // Pointer registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      page_q <= sfrc_pkg::RST_PAGE;
      col_q <= sfrc_pkg::RST_COL;
      wrap_q <= sfrc_pkg::WR_ARRAY;
      pg512_q <= 1'b0;
    end
    else
    begin
      page_q <= page_d;
      col_q <= col_d;
      wrap_q <= wrap_d;
      pg512_q <= pg512_d;
    end
  end

  assign ctr.page = page_q;
  assign ctr.col = col_q;

endmodule

`default_nettype wire

// ===== verilog/sfrc_read_seq.sv
`default_nettype none

module sfrc_read_seq (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic page_512_i,
  input wire logic [7:0] rd_data_i,
  output logic so_o,
  output logic so_oe_o,
  output logic rd_req_o,
  output logic rd_buf_o,
  output logic rd_buf_sel_o,
  output logic [12:0] rd_page_o,
  output logic [9:0] rd_col_o
);

  // Number of dummy bits that follow the address
  function automatic logic [5:0] dummy_of(input logic [7:0] op);
    case (op)
      sfrc_pkg::OP_ARR_LEGACY: dummy_of = sfrc_pkg::DUMMY_FOUR;
      sfrc_pkg::OP_PAGE_RD: dummy_of = sfrc_pkg::DUMMY_FOUR;
      sfrc_pkg::OP_ARR_FAST: dummy_of = sfrc_pkg::DUMMY_ONE;
      sfrc_pkg::OP_ARR_SLOW: dummy_of = sfrc_pkg::DUMMY_NONE;
      default: dummy_of = sfrc_pkg::DUMMY_ONE;
    endcase
  endfunction

  // Opcode is one of the supported reads
  function automatic logic op_known(input logic [7:0] op);
    case (op)
      sfrc_pkg::OP_ARR_LEGACY,
      sfrc_pkg::OP_ARR_FAST,
      sfrc_pkg::OP_ARR_SLOW,
      sfrc_pkg::OP_PAGE_RD,
      sfrc_pkg::OP_BUF1_FAST,
      sfrc_pkg::OP_BUF1_SLOW,
      sfrc_pkg::OP_BUF2_FAST,
      sfrc_pkg::OP_BUF2_SLOW: op_known = 1'b1;
      default: op_known = 1'b0;
    endcase
  endfunction

  // Wrap behaviour selected by the opcode
  function automatic sfrc_pkg::sfrc_wrap_t wrap_of(input logic [7:0] op);
    case (op)
      sfrc_pkg::OP_PAGE_RD: wrap_of = sfrc_pkg::WR_PAGE;
      sfrc_pkg::OP_ARR_LEGACY,
      sfrc_pkg::OP_ARR_FAST,
      sfrc_pkg::OP_ARR_SLOW: wrap_of = sfrc_pkg::WR_ARRAY;
      default: wrap_of = sfrc_pkg::WR_BUF;
    endcase
  endfunction

  // Page field of a 24-bit address
  function automatic logic [12:0] page_of(input logic [23:0] a, input logic pg512);
    if (pg512)
      page_of = a[sfrc_pkg::A512_PAGE_LSB +: sfrc_pkg::PAGE_W];
    else
      page_of = a[sfrc_pkg::A528_PAGE_LSB +: sfrc_pkg::PAGE_W];
  endfunction

  // Byte field of a 24-bit address, array or buffer alike
  function automatic logic [9:0] col_of(input logic [23:0] a, input logic pg512);
    if (pg512)
      col_of = {1'b0, a[8:0]};
    else
      col_of = a[9:0];
  endfunction

  // Pin history for edge detection
  logic sck_q;
  logic sck_d;
  logic cs_n_q;
  logic cs_n_d;
  logic sck_rise;
  logic sck_fall;

  // Command sequencer state
  sfrc_pkg::sfrc_state_t st_q;
  sfrc_pkg::sfrc_state_t st_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [23:0] sin_q;
  logic [23:0] sin_d;
  logic [5:0] dummy_q;
  logic [5:0] dummy_d;
  sfrc_pkg::sfrc_wrap_t wrap_q;
  sfrc_pkg::sfrc_wrap_t wrap_d;
  logic bsel_q;
  logic bsel_d;
  logic pg512_q;
  logic pg512_d;
  logic [7:0] op_now;
  logic [23:0] addr_now;
  logic ld;
  logic start;

  // Data output state
  logic so_q;
  logic so_d;
  logic oe_q;
  logic oe_d;
  logic [7:0] osh_q;
  logic [7:0] osh_d;
  logic [2:0] bitn_q;
  logic [2:0] bitn_d;
  logic [7:0] nxt_q;
  logic [7:0] nxt_d;
  logic req_q;
  logic req_d;
  logic wait_q;
  logic wait_d;
  logic rbuf_q;
  logic rbuf_d;
  logic rsel_q;
  logic rsel_d;
  logic step;

  sfrc_ctr_if u_ctr_if ();

  // Edges: input sampled on rise, output shifted on fall
  always_comb
  begin
    sck_d = sck_i;
    cs_n_d = cs_n_i;
    sck_rise = sck_i & ~sck_q;
    sck_fall = ~sck_i & sck_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
    end
    else
    begin
      sck_q <= sck_d;
      cs_n_q <= cs_n_d;
    end
  end

  // Opcode, address and dummy phases
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sin_d = sin_q;
    dummy_d = dummy_q;
    wrap_d = wrap_q;
    bsel_d = bsel_q;
    pg512_d = pg512_q;
    ld = 1'b0;
    start = 1'b0;
    op_now = {sin_q[6:0], si_i};
    addr_now = {sin_q[22:0], si_i};
    if (cs_n_i)
    begin
      st_d = sfrc_pkg::ST_IDLE;
    end
    else
    begin
      case (st_q)
        sfrc_pkg::ST_IDLE:
        begin
          if (cs_n_q)
          begin
            st_d = sfrc_pkg::ST_OPC;
            cnt_d = sfrc_pkg::RST_CNT;
            pg512_d = page_512_i;
          end
        end
        sfrc_pkg::ST_OPC:
        begin
          if (sck_rise)
          begin
            sin_d = addr_now;
            if (cnt_q == sfrc_pkg::OPC_LAST)
            begin
              cnt_d = sfrc_pkg::RST_CNT;
              if (op_known(op_now))
              begin
                st_d = sfrc_pkg::ST_ADDR;
                dummy_d = dummy_of(op_now);
                wrap_d = wrap_of(op_now);
                bsel_d = (op_now == sfrc_pkg::OP_BUF2_FAST) ||
                         (op_now == sfrc_pkg::OP_BUF2_SLOW);
              end
              else
              begin
                st_d = sfrc_pkg::ST_SKIP;
              end
            end
            else
            begin
              cnt_d = cnt_q + 6'h01;
            end
          end
        end
        sfrc_pkg::ST_ADDR:
        begin
          if (sck_rise)
          begin
            sin_d = addr_now;
            if (cnt_q == sfrc_pkg::ADDR_LAST)
            begin
              cnt_d = sfrc_pkg::RST_CNT;
              ld = 1'b1;
              if (dummy_q == sfrc_pkg::DUMMY_NONE)
              begin
                st_d = sfrc_pkg::ST_DATA;
                start = 1'b1;
              end
              else
              begin
                st_d = sfrc_pkg::ST_DUMMY;
              end
            end
            else
            begin
              cnt_d = cnt_q + 6'h01;
            end
          end
        end
        sfrc_pkg::ST_DUMMY:
        begin
          if (sck_rise)
          begin
            if (cnt_q == dummy_q - 6'h01)
            begin
              cnt_d = sfrc_pkg::RST_CNT;
              st_d = sfrc_pkg::ST_DATA;
              start = 1'b1;
            end
            else
            begin
              cnt_d = cnt_q + 6'h01;
            end
          end
        end
        sfrc_pkg::ST_DATA,
        sfrc_pkg::ST_SKIP:
        begin
          st_d = st_q;
        end
        default:
        begin
          st_d = sfrc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= sfrc_pkg::ST_IDLE;
      cnt_q <= sfrc_pkg::RST_CNT;
      sin_q <= sfrc_pkg::RST_SHIFT;
      dummy_q <= sfrc_pkg::DUMMY_NONE;
      wrap_q <= sfrc_pkg::WR_ARRAY;
      bsel_q <= 1'b0;
      pg512_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sin_q <= sin_d;
      dummy_q <= dummy_d;
      wrap_q <= wrap_d;
      bsel_q <= bsel_d;
      pg512_q <= pg512_d;
    end
  end

  // Pointer load and step requests
  assign u_ctr_if.ld = ld;
  assign u_ctr_if.step = step;
  assign u_ctr_if.ld_page = page_of(addr_now, pg512_q);
  assign u_ctr_if.ld_col = col_of(addr_now, pg512_q);
  assign u_ctr_if.ld_wrap = wrap_q;
  assign u_ctr_if.ld_pg512 = pg512_q;

  sfrc_addr_ctr u_addr_ctr (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ctr(u_ctr_if.ctr)
  );

  // Byte prefetch and serial shift-out
  always_comb
  begin
    so_d = so_q;
    oe_d = oe_q;
    osh_d = osh_q;
    bitn_d = bitn_q;
    nxt_d = nxt_q;
    req_d = 1'b0;
    wait_d = req_q;
    rbuf_d = rbuf_q;
    rsel_d = rsel_q;
    step = 1'b0;
    if (wait_q)
    begin
      nxt_d = rd_data_i; // Fetched byte lands here
    end
    if (cs_n_i)
    begin
      oe_d = 1'b0;
      bitn_d = sfrc_pkg::RST_BITN;
    end
    else if (start)
    begin
      req_d = 1'b1;
      bitn_d = sfrc_pkg::RST_BITN;
      rbuf_d = (wrap_q == sfrc_pkg::WR_BUF);
      rsel_d = bsel_q;
    end
    else if ((st_q == sfrc_pkg::ST_DATA) && sck_fall)
    begin
      oe_d = 1'b1;
      bitn_d = bitn_q + 3'h1;
      if (bitn_q == sfrc_pkg::RST_BITN)
      begin
        so_d = nxt_q[7];
        osh_d = {nxt_q[6:0], 1'b0};
        step = 1'b1;
        req_d = 1'b1;
      end
      else
      begin
        so_d = osh_q[7];
        osh_d = {osh_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
      osh_q <= sfrc_pkg::RST_BYTE;
      bitn_q <= sfrc_pkg::RST_BITN;
      nxt_q <= sfrc_pkg::RST_BYTE;
      req_q <= 1'b0;
      wait_q <= 1'b0;
      rbuf_q <= 1'b0;
      rsel_q <= 1'b0;
    end
    else
    begin
      so_q <= so_d;
      oe_q <= oe_d;
      osh_q <= osh_d;
      bitn_q <= bitn_d;
      nxt_q <= nxt_d;
      req_q <= req_d;
      wait_q <= wait_d;
      rbuf_q <= rbuf_d;
      rsel_q <= rsel_d;
    end
  end

  // Outputs, all from flip-flops
  assign so_o = so_q;
  assign so_oe_o = oe_q;
  assign rd_req_o = req_q;
  assign rd_buf_o = rbuf_q;
  assign rd_buf_sel_o = rsel_q;
  assign rd_page_o = u_ctr_if.page;
  assign rd_col_o = u_ctr_if.col;

endmodule

`default_nettype wire

// ===== tb/sfrc_mem_model.sv
`default_nettype none

module sfrc_mem_model (
  input wire logic clk_i,
  input wire logic rd_req_i,
  input wire logic rd_buf_i,
  input wire logic rd_buf_sel_i,
  input wire logic [12:0] rd_page_i,
  input wire logic [9:0] rd_col_i,
  output logic [7:0] rd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic held_q = 1'b0;
  logic [7:0] word;

  // Array and buffer contents as address patterns
  always_comb
  begin
    if (rd_buf_i)
      word = rd_col_i[7:0] ^ {rd_buf_sel_i, 2'h0, rd_col_i[9:8], 3'h5};
    else
      word = rd_page_i[7:0] ^ {rd_page_i[12:8], 3'h0} ^ rd_col_i[7:0] ^
             {rd_col_i[9:8], 6'h15};
  end

  // Answer stands for the request cycle and the next, else inverted
  always_ff @(posedge clk_i)
    held_q <= rd_req_i;
  assign rd_data_o = (rd_req_i || held_q) ? word : ~word;
endmodule

`default_nettype wire

// ===== tb/sfrc_read_seq_assertions.sv
`default_nettype none

module sfrc_read_seq_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic page_512_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic rd_req_o,
  input wire logic rd_buf_o,
  input wire logic rd_buf_sel_o,
  input wire logic [12:0] rd_page_o,
  input wire logic [9:0] rd_col_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Output release and start-up
  a_oe_cs_off: assert property (cs_n_i |=> !so_oe_o)
    else $error("SO still driven after chip select high");
  a_oe_rise_cause: assert property ($rose(so_oe_o) |->
    !$past(sck_i) && !$past(cs_n_i))
    else $error("SO enabled without a serial clock fall");
  a_oe_hdr_quiet: assert property ($fell(cs_n_i) |-> (!so_oe_o) [*8])
    else $error("SO driven during command header");
  a_so_hold_high: assert property (sck_i && !cs_n_i |=> $stable(so_o) || !so_oe_o)
    else $error("SO changed without a serial clock fall");
  // Fetch port
  a_req_one_cycle: assert property (rd_req_o |=> !rd_req_o)
    else $error("Fetch request longer than one cycle");
  a_req_addr_hold: assert property (rd_req_o |=>
    $stable({rd_buf_o, rd_buf_sel_o, rd_page_o, rd_col_o}))
    else $error("Fetch address moved during fetch");
  a_col_max_512: assert property (rd_req_o && page_512_i |-> rd_col_o <= 10'h1FF)
    else $error("Byte index beyond 512-byte page");
  a_col_max_528: assert property (rd_req_o && !page_512_i |-> rd_col_o <= 10'h20F)
    else $error("Byte index beyond 528-byte page");
endmodule

bind sfrc_read_seq sfrc_read_seq_checker sfrc_read_seq_checker_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
  .page_512_i(page_512_i), .so_o(so_o), .so_oe_o(so_oe_o), .rd_req_o(rd_req_o),
  .rd_buf_o(rd_buf_o), .rd_buf_sel_o(rd_buf_sel_o), .rd_page_o(rd_page_o),
  .rd_col_o(rd_col_o)
);

`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cs_n_i = 1'b1;
  logic sck_i = 1'b0;
  logic si_i = 1'b0;
  logic page_512_i = 1'b0;
  logic [7:0] rd_data_i;
  logic so_o, so_oe_o, rd_req_o, rd_buf_o, rd_buf_sel_o;
  logic [12:0] rd_page_o;
  logic [9:0] rd_col_o;
  wire so_pin = so_oe_o ? so_o : 1'bz;
  int n_mismatch = 0;
  int checked = 0;
  int seed = 32'hf43ff56f;
  logic [7:0] exp_q[$];
  logic [7:0] sh = 8'h00;
  int nb = 0;
  logic sck_q = 1'b0;

  always #2.5 clk_i = ~clk_i;

  sfrc_read_seq sfrc_read_seq_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i),
    .page_512_i(page_512_i), .rd_data_i(rd_data_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .rd_req_o(rd_req_o), .rd_buf_o(rd_buf_o), .rd_buf_sel_o(rd_buf_sel_o),
    .rd_page_o(rd_page_o), .rd_col_o(rd_col_o)
  );

  sfrc_mem_model sfrc_mem_model_i (
    .clk_i(clk_i), .rd_req_i(rd_req_o), .rd_buf_i(rd_buf_o), .rd_buf_sel_i(rd_buf_sel_o),
    .rd_page_i(rd_page_o), .rd_col_i(rd_col_o), .rd_data_o(rd_data_i)
  );

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Expected memory byte, same patterns as the memory model
  function automatic logic [7:0] pat(logic b, logic s, logic [12:0] p, logic [9:0] c);
    if (b)
      return c[7:0] ^ {s, 2'h0, c[9:8], 3'h5};
    return p[7:0] ^ {p[12:8], 3'h0} ^ c[7:0] ^ {c[9:8], 6'h15};
  endfunction

  // One serial clock period: low phase then high phase, 4 clocks each
  task automatic sbit(input logic b);
    @(negedge clk_i);
    sck_i = 1'b0;
    si_i = b;
    repeat (4) @(negedge clk_i); // Slow enough for every buffer opcode
    sck_i = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask

  // Whole command: header, data bytes, optional partial byte, then release
  task automatic cmd(input logic [7:0] op, input logic p5, input logic m3,
                     input logic [12:0] pg, input logic [9:0] col, input int nby,
                     input int part);
    logic [31:0] hd;
    logic [9:0] last;
    logic bf, sl, ar;
    int nd;
    hd = {op, 24'($random(seed))};
    if (p5)
      hd[21:0] = {pg, col[8:0]};
    else
      hd[22:0] = {pg, col};
    bf = op inside {8'hD4, 8'hD1, 8'hD6, 8'hD3};
    sl = op inside {8'hD6, 8'hD3};
    ar = op inside {8'hE8, 8'h0B, 8'h03};
    nd = (op == 8'h03) ? 0 : 8;
    if (op == 8'hE8 || op == 8'hD2)
      nd = 32;
    last = p5 ? 10'h1FF : 10'h20F;
    if (p5)
      col[9] = 1'b0;
    @(negedge clk_i);
    page_512_i = p5;
    sck_i = m3;
    @(negedge clk_i);
    cs_n_i = 1'b0;
    for (int i = 31; i >= 0; i--)
      sbit(hd[i]);
    repeat (nd) sbit(1'($random(seed)));
    for (int k = 0; k < nby; k++)
    begin
      exp_q.push_back(pat(bf, sl, pg, col));
      if (col == last)
      begin
        col = 10'h000;
        if (ar)
          pg = pg + 13'h0001;
      end
      else
        col = col + 10'h001;
      repeat (8) sbit(1'($random(seed)));
    end
    repeat (part) sbit(1'b0);
    @(negedge clk_i);
    cs_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("so_oe_idle", {7'h00, so_oe_o}, 8'h00);
    chk("bytes_left", 8'(exp_q.size()), 8'h00);
    exp_q.delete();
    $display("test op %h done", op);
  endtask

  // Collects SO bits on serial clock rises and compares whole bytes
  always @(posedge clk_i)
  begin
    sck_q <= sck_i;
    if (cs_n_i)
      nb = 0;
    else if (so_oe_o === 1'b1 && sck_i && !sck_q)
    begin
      sh = {sh[6:0], so_pin};
      nb++;
      if (nb == 8)
      begin
        nb = 0;
        if (exp_q.size() == 0)
          chk("extra_byte", 8'h01, 8'h00);
        else
          chk("so_byte", sh, exp_q.pop_front());
      end
    end
  end

  // Watchdog against a hung sequence
  initial
  begin
    #400us;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk("rst_oe", {7'h00, so_oe_o}, 8'h00);
    chk("rst_req", {7'h00, rd_req_o}, 8'h00);
    cmd(8'h03, 1'b0, 1'b0, 13'h0005, 10'h20D, 4, 0);
    cmd(8'h0B, 1'b1, 1'b1, 13'h1FFF, 10'h1FE, 3, 0);
    cmd(8'hE8, 1'b0, 1'b0, 13'h1FFF, 10'h20F, 2, 0);
    cmd(8'hD2, 1'b1, 1'b0, 13'h004D, 10'h1FE, 3, 0);
    cmd(8'hD2, 1'b0, 1'b1, 13'h0003, 10'h20E, 3, 0);
    cmd(8'hD4, 1'b0, 1'b0, 13'h0000, 10'h20E, 3, 0);
    cmd(8'hD1, 1'b1, 1'b1, 13'h0000, 10'h1FF, 2, 0);
    cmd(8'hD6, 1'b1, 1'b0, 13'h0000, 10'h000, 2, 0);
    cmd(8'hD3, 1'b0, 1'b1, 13'h0000, 10'h20F, 2, 0);
    cmd(8'h55, 1'b0, 1'b0, 13'h0001, 10'h001, 0, 40);
    cmd(8'h03, 1'b0, 1'b0, 13'h0A00, 10'h100, 2, 3);
    cmd(8'h0B, 1'b0, 1'b1, 13'h0A01, 10'h000, 1, 0);
    conclude();
  end
endmodule

`default_nettype wire
